// [bench/fdprr_checker.sv]
// port assertions of the register bank
`timescale 1ns/10ps
`default_nettype none
`include "fdprr_map.svh"
module fdprr_checker
   import fdprr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] meas_current,
   input wire logic [7:0] rdata,
   input wire logic [7:0] cur_setting,
   input wire logic [1:0] mode,
   input wire logic pwm_on,
   input wire logic [7:0] amp,
   input wire logic skip_ok
);
   logic [6:0] run_r;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!reset_n);
   // length of the present pulse; frozen cycles do not count
   always_ff @(posedge clk)
      run_r <= (!reset_n || !pwm_on) ? 7'h00 : run_r + {6'h00, clk_en};
   AST_CUR_WR: assert property (clk_en && wr_en && addr == `FDPRR_OFS_CUR_A |=> cur_setting == $past(wdata))
      else $error("current write lost");
   AST_AMP_IND: assert property (mode == FDPRR_MODE_IND && $stable(mode) && $stable(cur_setting)
      |-> amp == (cur_setting & `FDPRR_AMP_MASK)) else $error("indicator amplitude wrong");
   AST_SKIP_IND: assert property (mode == FDPRR_MODE_IND && $stable(mode) |-> skip_ok)
      else $error("indicator without skip");
   AST_SKIP_FIX: assert property (!skip_ok && $stable(mode) && $stable(cur_setting)
      |-> mode[1] && cur_setting >= `FDPRR_FIXED_LEVEL) else $error("skip barred wrongly");
   AST_PWM_GATE: assert property (pwm_on && $stable(mode) |-> mode == FDPRR_MODE_IND)
      else $error("pulse outside indicator");
   AST_PWM_MAX: assert property (run_r <= 7'(4 * `FDPRR_SLOT_CYC))
      else $error("pulse too long");
   AST_RD_ACT: assert property (clk_en && rd_en && addr == `FDPRR_OFS_ACT && $stable(meas_current)
      |=> rdata == $past(meas_current)) else $error("present current wrong");
   AST_RD_GAP: assert property (clk_en && rd_en && addr inside {[4'hA:4'hD]} |=> rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : fdprr_checker
bind fdprr_regs fdprr_checker i_chk (.*);
`default_nettype wire

// [bench/fdprr_host.sv]
// host model making register accesses
`timescale 1ns/10ps
`default_nettype none
module fdprr_host
(
   input wire logic clk,
   output logic wr_en,
   output logic rd_en,
   output logic rd_done,
   output logic [3:0] addr,
   output logic [7:0] wdata
);
   initial
      {wr_en, rd_en, rd_done, addr, wdata} = '0;
   // callers hand only defined bits to writable registers, undefined ones zero
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      {wr_en, addr, wdata} = {1'b1, a, d};
      @(negedge clk);
      {wr_en, addr, wdata} = {1'b0, ~a, ~d};
   endtask : wr
   // the finish strobe trails the read so the clear follows it
   task automatic rd(input logic [3:0] a);
      @(negedge clk);
      {rd_en, addr} = {1'b1, a};
      @(negedge clk);
      {rd_en, addr} = {1'b0, ~a};
      @(negedge clk) rd_done = 1'b1;
      @(negedge clk) rd_done = 1'b0;
   endtask : rd
endmodule : fdprr_host
`default_nettype wire

// [bench/fdprr_regs_tb.sv]
// self-checking bench of the register bank
`timescale 1ns/10ps
`default_nettype none
`include "fdprr_map.svh"
module fdprr_regs_tb;
   logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, uv_reduce = 1'b0, flash_end = 1'b0, rd_seen = 1'b0;
   logic wr_en, rd_en, rd_done, out_on, pwm_on, skip_ok;
   logic [1:0] mode;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, cur_setting, amp, v, meas_current = 8'h00, supply_current = 8'h00, fault_events = 8'h00;
   logic [7:0] rst[16] = '{0: `FDPRR_PART_CODE, 1: 8'h9C, 2: 8'h9C, 3: 8'h68, 4: 8'h2C, 5: 8'h23, 7: 8'hC0, default: 8'h00};
   logic [7:0] msk[16] = '{6: 8'h03, 7: 8'hC0, 9: 8'h07, default: 8'hFF};
   logic [7:0] rfmask_cfg, supply_cfg, timer_cfg, trig_cfg;
   logic [7:0] exp_q[$];
   int err_count = 0, check_count = 0, seed = 32'hd70c, n;
   always #50 clk = ~clk;
   fdprr_host i_host (.clk, .wr_en, .rd_en, .rd_done, .addr, .wdata);
   fdprr_regs i_dut (.clk, .reset_n, .clk_en, .wr_en, .rd_en, .rd_done, .addr, .wdata, .meas_current, .supply_current,
      .uv_reduce, .fault_events, .flash_end, .rdata, .cur_setting, .mode, .out_on, .pwm_on, .amp, .skip_ok,
      .rfmask_cfg, .supply_cfg, .timer_cfg, .trig_cfg);
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want)
      begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : chk
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.rd(a);
   endtask : rd
   task automatic sk(input logic [3:0] a, input logic [7:0] d, input logic e);
      i_host.wr(a, d);
      repeat (2) @(negedge clk);
      chk({7'h00, skip_ok}, {7'h00, e});
   endtask : sk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge clk)
      rd_seen <= rd_en & clk_en & reset_n;
   always @(negedge clk)
      if (rd_seen)
         chk(rdata, exp_q.pop_front());
   initial
   begin
      #2000000;
      err_count++;
      wrap_up();
   end
   initial
   begin
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      for (n = 0; n < 16; n++)
         rd(n[3:0], rst[n]);
      $display("reset values done");
      for (n = 0; n < 16; n++)
      begin
         if (n != 2)
            v = 8'($random(seed)) & msk[n];
         i_host.wr(n[3:0], v);
         if (n == 3 || n == 4 || n == 5 || n == 7)
            chk((n == 3) ? rfmask_cfg : (n == 4) ? supply_cfg : (n == 5) ? timer_cfg : trig_cfg, v);
         rd(n[3:0], (n == 0 || n == 8 || n > 9) ? rst[n] : v);
      end
      $display("readback done");
      @(negedge clk) fault_events = 8'hFF;
      @(negedge clk) fault_events = 8'h00;
      rd(4'h8, `FDPRR_FAULT_MASK);
      rd(4'h8, 8'h00);
      $display("fault clear done");
      i_host.wr(4'h6, 8'h09);
      chk({7'h00, out_on}, 8'h01);
      for (int s = 0; s < 4; s++)
      begin
         sk(4'h9, 8'(s | 4), 1'b1);
         repeat (`FDPRR_SLOTS * `FDPRR_SLOT_CYC) @(negedge clk);
         n = 0;
         repeat (`FDPRR_SLOTS * `FDPRR_SLOT_CYC) @(negedge clk) n += int'(pwm_on);
         chk(8'(n), 8'((s + 1) * `FDPRR_SLOT_CYC));
      end
      $display("pulse duty done");
      i_host.wr(4'h2, 8'h40);
      i_host.wr(4'h1, 8'h40);
      sk(4'h6, 8'h0A, 1'b0);
      sk(4'h1, 8'h3F, 1'b1);
      sk(4'h1, 8'h40, 1'b0);
      sk(4'h9, 8'h03, 1'b1);
      $display("switching done");
      i_host.wr(4'h6, 8'h00);
      i_host.wr(4'h6, 8'h0B);
      @(negedge clk) {uv_reduce, supply_current} = 9'h150;
      @(negedge clk) supply_current = 8'h30;
      @(negedge clk) supply_current = 8'h60;
      @(negedge clk) {uv_reduce, flash_end} = 2'b01;
      @(negedge clk) flash_end = 1'b0;
      chk({7'h00, out_on}, 8'h00);
      rd(4'h6, 8'h00);
      rd(4'hE, 8'h30);
      i_host.wr(4'h6, 8'h0B);
      rd(4'hE, 8'h00);
      v = 8'($random(seed));
      meas_current = v;
      rd(4'hF, v);
      rd(4'hF, v);
      $display("current readback done");
      i_host.wr(4'h5, 8'h11);
      clk_en = 1'b0;
      i_host.wr(4'h5, 8'h22);
      clk_en = 1'b1;
      rd(4'h5, 8'h11);
      chk(timer_cfg, 8'h11);
      $display("clock enable done");
      wrap_up();
   end
endmodule : fdprr_regs_tb
`default_nettype wire

// [verilog/fdprr_map.svh]
// register offsets, reset values, field positions and timing counts of the flash driver register bank
`ifndef FDPRR_MAP_SVH
`define FDPRR_MAP_SVH
`define FDPRR_OFS_ID 4'h0
`define FDPRR_OFS_CUR_A 4'h1
`define FDPRR_OFS_CUR_B 4'h2
`define FDPRR_OFS_RFMASK 4'h3
`define FDPRR_OFS_SUPPLY 4'h4
`define FDPRR_OFS_TIMER 4'h5
`define FDPRR_OFS_CTRL 4'h6
`define FDPRR_OFS_TRIG 4'h7
`define FDPRR_OFS_FAULT 4'h8
`define FDPRR_OFS_PWM 4'h9
`define FDPRR_OFS_MIN 4'hE
`define FDPRR_OFS_ACT 4'hF
`define FDPRR_RST_CUR 8'h9C
`define FDPRR_RST_RFMASK 8'h68
`define FDPRR_RST_SUPPLY 8'h2C
`define FDPRR_RST_TIMER 8'h23
`define FDPRR_RST_CTRL 8'h00
`define FDPRR_RST_TRIG 8'hC0
`define FDPRR_RST_FAULT 8'h00
`define FDPRR_RST_PWM 8'h00
`define FDPRR_RST_MIN 8'h00
// arbitrary value, not a real part code
`define FDPRR_PART_CODE 8'hA5
`define FDPRR_CTRL_MASK 8'h0B
`define FDPRR_TRIG_MASK 8'hC0
`define FDPRR_FAULT_MASK 8'hF9
`define FDPRR_PWM_MASK 8'h07
`define FDPRR_BIT_UVLO 0
`define FDPRR_BIT_FREQ 2
`define FDPRR_FIXED_LEVEL 8'h40
`define FDPRR_AMP_MASK 8'h3F
`define FDPRR_CLK_HZ 10000000
`define FDPRR_PWM_HZ 31250
`define FDPRR_SLOTS 16
`define FDPRR_SLOT_CYC (`FDPRR_CLK_HZ / (`FDPRR_PWM_HZ * `FDPRR_SLOTS))
`endif

// [verilog/fdprr_pkg.sv]
// types of the flash driver register bank
package fdprr_pkg;
   typedef enum logic [1:0] {
      FDPRR_MODE_OFF = 2'b00,
      FDPRR_MODE_IND = 2'b01,
      FDPRR_MODE_ASSIST = 2'b10,
      FDPRR_MODE_FLASH = 2'b11
   } fdprr_mode_type;

   typedef struct packed {
      logic [7:0] cur_a;
      logic [7:0] cur_b;
      logic [7:0] rfmask;
      logic [7:0] supply;
      logic [7:0] timer;
      logic [7:0] ctrl;
      logic [7:0] trig;
      logic [7:0] fault;
      logic [7:0] pwm;
      logic [7:0] min_cur;
      logic [7:0] act_cur;
      logic [7:0] rdata;
      logic rd_pend;
      logic [3:0] rd_addr;
      logic cycle_on;
      logic [4:0] slot_cnt;
      logic [3:0] phase;
      logic pwm_on;
      logic [7:0] amp;
      logic skip_ok;
   } fdprr_state_type;
endpackage : fdprr_pkg

// [verilog/fdprr_regs.sv]
// register bank with pwm duty, switching-mode choice and current readback
`timescale 1ns/10ps
`default_nettype none
`include "fdprr_map.svh"
module fdprr_regs
   import fdprr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic rd_done,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] meas_current,
   input wire logic [7:0] supply_current,
   input wire logic uv_reduce,
   input wire logic [7:0] fault_events,
   input wire logic flash_end,
   output logic [7:0] rdata,
   output logic [7:0] cur_setting,
   output logic [1:0] mode,
   output logic out_on,
   output logic pwm_on,
   output logic [7:0] amp,
   output logic skip_ok,
   output logic [7:0] rfmask_cfg,
   output logic [7:0] supply_cfg,
   output logic [7:0] timer_cfg,
   output logic [7:0] trig_cfg
);
   localparam int SLOT_CYC = `FDPRR_SLOT_CYC;
   localparam logic [4:0] SLOT_LAST = 5'(SLOT_CYC - 1);

   fdprr_state_type s_r;
   fdprr_state_type s_nxt;
   fdprr_mode_type mode_w;
   logic [7:0] clr_mask;
   logic [7:0] low_cur;

   always_comb
   begin
      s_nxt = s_r;
      mode_w = fdprr_mode_type'(s_r.ctrl[1:0]);
      clr_mask = 8'h00;
      low_cur = s_r.min_cur;
      // read data latched at request, clear happens after the host finishes
      if (rd_en)
      begin
         s_nxt.rd_pend = 1'b1;
         s_nxt.rd_addr = addr;
         unique case (addr)
            `FDPRR_OFS_ID: s_nxt.rdata = `FDPRR_PART_CODE;
            `FDPRR_OFS_CUR_A: s_nxt.rdata = s_r.cur_a;
            `FDPRR_OFS_CUR_B: s_nxt.rdata = s_r.cur_b;
            `FDPRR_OFS_RFMASK: s_nxt.rdata = s_r.rfmask;
            `FDPRR_OFS_SUPPLY: s_nxt.rdata = s_r.supply;
            `FDPRR_OFS_TIMER: s_nxt.rdata = s_r.timer;
            `FDPRR_OFS_CTRL: s_nxt.rdata = s_r.ctrl;
            `FDPRR_OFS_TRIG: s_nxt.rdata = s_r.trig;
            `FDPRR_OFS_FAULT: s_nxt.rdata = s_r.fault;
            `FDPRR_OFS_PWM: s_nxt.rdata = s_r.pwm;
            `FDPRR_OFS_MIN: s_nxt.rdata = s_r.min_cur;
            `FDPRR_OFS_ACT: s_nxt.rdata = s_r.act_cur;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
      if (rd_done && s_r.rd_pend)
      begin
         s_nxt.rd_pend = 1'b0;
         // only bits the host actually saw are cleared, so a later event is not lost
         if (s_r.rd_addr == `FDPRR_OFS_FAULT)
         begin
            clr_mask = s_r.rdata;
         end
      end
      if (wr_en)
      begin
         unique case (addr)
            `FDPRR_OFS_CUR_A: s_nxt.cur_a = wdata;
            `FDPRR_OFS_CUR_B: s_nxt.cur_b = wdata;
            `FDPRR_OFS_RFMASK: s_nxt.rfmask = wdata;
            `FDPRR_OFS_SUPPLY: s_nxt.supply = wdata;
            `FDPRR_OFS_TIMER: s_nxt.timer = wdata;
            `FDPRR_OFS_CTRL: s_nxt.ctrl = wdata & `FDPRR_CTRL_MASK;
            `FDPRR_OFS_TRIG: s_nxt.trig = wdata & `FDPRR_TRIG_MASK;
            `FDPRR_OFS_PWM: s_nxt.pwm = wdata & `FDPRR_PWM_MASK;
            default: ;
         endcase
      end
      // a new event in the clearing cycle survives
      s_nxt.fault = ((s_r.fault & ~clr_mask) | fault_events | {7'h00, uv_reduce}) & `FDPRR_FAULT_MASK;
      // flash end clears mode and enable
      if (flash_end && mode_w == FDPRR_MODE_FLASH)
      begin
         s_nxt.ctrl = s_r.ctrl & 8'hF4;
      end
      s_nxt.act_cur = meas_current;
      // minimum tracking: restart at each new cycle, keep zero until a cut occurs
      if (s_r.ctrl[3] && !s_r.cycle_on)
      begin
         s_nxt.cycle_on = 1'b1;
         s_nxt.min_cur = 8'h00;
         low_cur = 8'h00;
      end
      else if (!s_r.ctrl[3])
      begin
         s_nxt.cycle_on = 1'b0;
      end
      if (s_r.ctrl[3] && uv_reduce)
      begin
         if (low_cur == 8'h00 || supply_current < low_cur)
         begin
            s_nxt.min_cur = supply_current;
         end
      end
      // pwm: 16 slots per period, duty slots = select + 1
      if (s_r.slot_cnt == SLOT_LAST)
      begin
         s_nxt.slot_cnt = 5'h00;
         s_nxt.phase = s_r.phase + 4'h1;
      end
      else
      begin
         s_nxt.slot_cnt = s_r.slot_cnt + 5'h01;
      end
      s_nxt.pwm_on = (mode_w == FDPRR_MODE_IND) && s_r.ctrl[3]
         && ({2'b00, s_r.phase[3:2]} == 4'h0) && (s_r.phase[1:0] <= s_r.pwm[1:0]) ;
      unique case (mode_w)
         FDPRR_MODE_IND: s_nxt.amp = s_r.cur_a & `FDPRR_AMP_MASK;
         FDPRR_MODE_ASSIST: s_nxt.amp = {1'b0, s_r.cur_a[6:0]};
         FDPRR_MODE_FLASH: s_nxt.amp = s_r.cur_a;
         FDPRR_MODE_OFF: s_nxt.amp = 8'h00;
      endcase
      if (!s_r.pwm[`FDPRR_BIT_FREQ])
      begin
         s_nxt.skip_ok = 1'b1;
      end
      else if (mode_w == FDPRR_MODE_IND || mode_w == FDPRR_MODE_OFF)
      begin
         s_nxt.skip_ok = 1'b1;
      end
      else
      begin
         s_nxt.skip_ok = s_r.cur_a < `FDPRR_FIXED_LEVEL;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_r <= '0;
         s_r.cur_a <= `FDPRR_RST_CUR;
         s_r.cur_b <= `FDPRR_RST_CUR;
         s_r.rfmask <= `FDPRR_RST_RFMASK;
         s_r.supply <= `FDPRR_RST_SUPPLY;
         s_r.timer <= `FDPRR_RST_TIMER;
         s_r.ctrl <= `FDPRR_RST_CTRL;
         s_r.trig <= `FDPRR_RST_TRIG;
         s_r.fault <= `FDPRR_RST_FAULT;
         s_r.pwm <= `FDPRR_RST_PWM;
         s_r.min_cur <= `FDPRR_RST_MIN;
         s_r.skip_ok <= 1'b1;
      end
      else if (clk_en)
      begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign cur_setting = s_r.cur_a;
   assign mode = s_r.ctrl[1:0];
   assign out_on = s_r.ctrl[3];
   assign pwm_on = s_r.pwm_on;
   assign amp = s_r.amp;
   assign skip_ok = s_r.skip_ok;
   assign rfmask_cfg = s_r.rfmask;
   assign supply_cfg = s_r.supply;
   assign timer_cfg = s_r.timer;
   assign trig_cfg = s_r.trig;
endmodule : fdprr_regs
`default_nettype wire
